/* File: common/uls_pkg.sv */
// Constants, register map and carrier types of the channel level/status block
// Behaviour
// - Receive interrupt threshold: 8-bit read-write register, resets to zero.
// - Lower flow-control threshold: 8-bit read-write register, resets to zero.
// - Upper flow-control threshold: 8-bit read-write register, resets to zero.
// - Auto RTS in enhanced mode: high at upper threshold, released below lower.
// - Prescale N factor, bits 3:0, read-write, resets to zero.
// - Special function bit 6 picks receive or status queue count at 0x15.
// - Receive queue count readable as 8-bit read-only value, resets to zero.
// - Status queue count readable as 8-bit read-only value, resets to zero.
// - Offset 0x16 shows transmit count when bit 7 set, else oversample select.
// - Transmit queue count readable as 8-bit read-only value, resets to zero.
// - Oversample code 0 gives 16, down to code 12 giving 4; upper bits zero.
// - Summary bit 0 set while receive queue holds data.
// - Summary bit 1 reports receive overrun.
// - Summary bits 2 and 3 report parity and framing errors.
// - Summary bit 4 reports a receive break.
// - Summary bit 5 high while transmit holding stage is empty.
// - Summary bit 6 high while transmit shift stage is empty.
// - Summary bit 7 high while any queued receive character has an error.
package uls_pkg;

	localparam int ULS_ADDR_W   = 10;
	localparam int ULS_BUS_W    = 32;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_SPECIAL_FN   = 8'h07;
	localparam logic [7:0] IDX_RX_IRQ_THR   = 8'h11;
	localparam logic [7:0] IDX_FLOW_LOW     = 8'h12;
	localparam logic [7:0] IDX_FLOW_HIGH    = 8'h13;
	localparam logic [7:0] IDX_PRESCALE     = 8'h14;
	localparam logic [7:0] IDX_RX_STAT_CNT  = 8'h15;
	localparam logic [7:0] IDX_TX_OVS       = 8'h16;
	localparam logic [7:0] IDX_LINE_SUMMARY = 8'h17;
	localparam logic [7:0] IDX_CHAN_CTRL    = 8'h18;

	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [3:0] RST_NIBBLE = 4'h0;

	// Field positions
	localparam int SFN_RX_SEL_BIT  = 6;
	localparam int SFN_TX_SEL_BIT  = 7;
	localparam int CTRL_ENH_BIT    = 0;
	localparam int CTRL_ARTS_BIT   = 1;
	localparam int PRE_N_LSB       = 0;
	localparam int PRE_M_LSB       = 4;
	localparam int SUM_RX_AVAIL    = 0;
	localparam int SUM_OVERRUN     = 1;
	localparam int SUM_PARITY      = 2;
	localparam int SUM_FRAME       = 3;
	localparam int SUM_BREAK       = 4;
	localparam int SUM_THR_EMPTY   = 5;
	localparam int SUM_TSR_EMPTY   = 6;
	localparam int SUM_DATA_ERR    = 7;

	// Oversampling: count = base - code, codes above max are reserved
	localparam logic [4:0] OVS_BASE     = 5'h10;
	localparam logic [3:0] OVS_CODE_MAX = 4'hC;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	typedef struct packed {
		logic [7:0] rx_count;
		logic [7:0] status_count;
		logic [7:0] tx_count;
		logic       rx_overrun;
		logic       rx_parity_err;
		logic       rx_frame_err;
		logic       rx_break;
		logic       tx_hold_empty;
		logic       tx_shift_empty;
		logic       rx_queue_err;
	} uls_chan_in_t;

	typedef struct packed {
		logic rts_n;
		logic rx_data_irq;
		logic sample_tick;
		logic baud_tick;
	} uls_chan_out_t;

endpackage

/* File: hw/uls_regs.sv */
// Channel level, count and line summary registers behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module uls_regs
	import uls_pkg::*;
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [ULS_ADDR_W-1:0] haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [ULS_BUS_W-1:0]  hwdata,
	input  wire logic                  hready,
	output logic      [ULS_BUS_W-1:0]  hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire uls_chan_in_t          chan_in,
	output uls_chan_out_t              chan_out
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0] special_function_control;
	logic [7:0] chan_ctrl;
	logic [7:0] rx_irq_threshold;
	logic [7:0] flow_low_threshold;
	logic [7:0] flow_high_threshold;
	logic [7:0] baud_prescale;
	logic [3:0] oversample_select;
	logic [7:0] global_line_summary;

	logic       wr_pend;
	logic [7:0] wr_idx;

	logic [7:0] pre_cnt;
	logic [4:0] ovs_cnt;

	////////////////////////////////////////////////////////////////////////
	// Address phase decode

	wire        acc_valid;
	wire        acc_ok;
	wire [7:0]  acc_idx;
	wire        rd_take;
	wire        wr_take;

	assign acc_valid = hsel && hready &&
		(htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	// Misaligned or narrow accesses land as unmapped: OKAY, no effect
	assign acc_ok  = (hsize == HSIZE_WORD) && (haddr[1:0] == 2'h0);
	assign acc_idx = haddr[ULS_ADDR_W-1:2];
	assign rd_take = acc_valid && acc_ok && !hwrite;
	assign wr_take = acc_valid && acc_ok && hwrite;

	////////////////////////////////////////////////////////////////////////
	// Read selection

	wire        sel_rx_count;
	wire        sel_tx_count;
	wire [7:0]  rx_stat_word;
	wire [7:0]  tx_ovs_word;
	wire [3:0]  prescale_n_factor;
	wire [3:0]  prescale_m_factor;
	logic [7:0] rd_byte;

	// A set bit picks the receive count
	assign sel_rx_count = special_function_control[SFN_RX_SEL_BIT];
	assign sel_tx_count = special_function_control[SFN_TX_SEL_BIT];
	assign rx_stat_word = sel_rx_count ? chan_in.rx_count
	                                   : chan_in.status_count;
	assign tx_ovs_word  = sel_tx_count ? chan_in.tx_count
	                                   : {4'h0, oversample_select};
	assign prescale_n_factor = baud_prescale[PRE_N_LSB +: 4];
	assign prescale_m_factor = baud_prescale[PRE_M_LSB +: 4];

	always_comb begin
		unique case (acc_idx)
			IDX_SPECIAL_FN:   rd_byte = special_function_control;
			IDX_RX_IRQ_THR:   rd_byte = rx_irq_threshold;
			IDX_FLOW_LOW:     rd_byte = flow_low_threshold;
			IDX_FLOW_HIGH:    rd_byte = flow_high_threshold;
			IDX_PRESCALE:     rd_byte = {prescale_m_factor, prescale_n_factor};
			IDX_RX_STAT_CNT:  rd_byte = rx_stat_word;
			IDX_TX_OVS:       rd_byte = tx_ovs_word;
			IDX_LINE_SUMMARY: rd_byte = global_line_summary;
			IDX_CHAN_CTRL:    rd_byte = chan_ctrl;
			default:          rd_byte = RST_BYTE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Bus response: zero wait state, always OKAY

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= 1'b0;
			wr_idx    <= RST_BYTE;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= wr_take;
			wr_idx    <= acc_idx;
			hrdata    <= rd_take ? {24'h0, rd_byte} : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data phase writes

	wire [7:0] wbyte;
	wire       wr_sfn;
	wire       wr_ctrl;
	wire       wr_rtl;
	wire       wr_fcl;
	wire       wr_fch;
	wire       wr_pre;
	wire       wr_ovs;

	assign wbyte   = hwdata[7:0];
	assign wr_sfn  = wr_pend && (wr_idx == IDX_SPECIAL_FN);
	assign wr_ctrl = wr_pend && (wr_idx == IDX_CHAN_CTRL);
	assign wr_rtl  = wr_pend && (wr_idx == IDX_RX_IRQ_THR);
	assign wr_fcl  = wr_pend && (wr_idx == IDX_FLOW_LOW);
	assign wr_fch  = wr_pend && (wr_idx == IDX_FLOW_HIGH);
	assign wr_pre  = wr_pend && (wr_idx == IDX_PRESCALE);
	// Counts are read-only, so the shared offset only takes writes as select
	assign wr_ovs  = wr_pend && (wr_idx == IDX_TX_OVS) && !sel_tx_count;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			special_function_control <= RST_BYTE;
			chan_ctrl                <= RST_BYTE;
		end else begin
			if (wr_sfn)
				special_function_control <= wbyte;
			if (wr_ctrl)
				chan_ctrl <= {6'h0, wbyte[1:0]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_irq_threshold    <= RST_BYTE;
			flow_low_threshold  <= RST_BYTE;
			flow_high_threshold <= RST_BYTE;
		end else begin
			if (wr_rtl)
				rx_irq_threshold <= wbyte;
			if (wr_fcl)
				flow_low_threshold <= wbyte;
			if (wr_fch)
				flow_high_threshold <= wbyte;
		end
	end

	// M values above 2 are stored as written; only software keeps them low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			baud_prescale     <= RST_BYTE;
			oversample_select <= RST_NIBBLE;
		end else begin
			if (wr_pre)
				baud_prescale <= wbyte;
			if (wr_ovs)
				oversample_select <= wbyte[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Line status summary, sampled each cycle

	wire [7:0] next_global_line_summary;

	assign next_global_line_summary[SUM_RX_AVAIL]  =
		(chan_in.rx_count != 8'h00);
	assign next_global_line_summary[SUM_OVERRUN]   =
		chan_in.rx_overrun;
	assign next_global_line_summary[SUM_PARITY]    =
		chan_in.rx_parity_err;
	assign next_global_line_summary[SUM_FRAME]     =
		chan_in.rx_frame_err;
	assign next_global_line_summary[SUM_BREAK]     =
		chan_in.rx_break;
	assign next_global_line_summary[SUM_THR_EMPTY] =
		chan_in.tx_hold_empty;
	assign next_global_line_summary[SUM_TSR_EMPTY] =
		chan_in.tx_shift_empty;
	assign next_global_line_summary[SUM_DATA_ERR]  =
		chan_in.rx_queue_err;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			global_line_summary <= RST_BYTE;
		else
			global_line_summary <= next_global_line_summary;
	end

	////////////////////////////////////////////////////////////////////////
	// Flow control and receive interrupt condition

	wire auto_rts_on;
	wire rts_assert_hi;
	wire rts_release;
	wire next_rts_n;

	assign auto_rts_on   = chan_ctrl[CTRL_ENH_BIT] && chan_ctrl[CTRL_ARTS_BIT];
	assign rts_assert_hi = chan_in.rx_count >= flow_high_threshold;
	assign rts_release   = chan_in.rx_count < flow_low_threshold;
	// High threshold wins when the two thresholds are misprogrammed
	assign next_rts_n = !auto_rts_on ? 1'b0 :
	                    rts_assert_hi ? 1'b1 :
	                    rts_release ? 1'b0 : chan_out.rts_n;

	wire next_rx_data_irq;

	assign next_rx_data_irq =
		(chan_in.rx_count >= rx_irq_threshold);

	////////////////////////////////////////////////////////////////////////
	// Baud generator: prescale divide, then oversample divide

	wire [7:0] pre_limit;
	wire       pre_wrap;
	wire [4:0] ovs_count;
	wire [4:0] ovs_limit;
	wire       ovs_wrap;

	// Divide by {M,N}+1; zero means no prescale, the safe reset state
	assign pre_limit = {prescale_m_factor, prescale_n_factor};
	assign pre_wrap  = (pre_cnt >= pre_limit);
	// Reserved codes fall back to the widest oversample to stay harmless
	assign ovs_count = (oversample_select > OVS_CODE_MAX) ? OVS_BASE :
	                   OVS_BASE - {1'b0, oversample_select};
	assign ovs_limit = ovs_count - 5'h01;
	assign ovs_wrap  = pre_wrap && (ovs_cnt >= ovs_limit);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_cnt <= RST_BYTE;
			ovs_cnt <= 5'h00;
		end else begin
			pre_cnt <= pre_wrap ? 8'h00 : pre_cnt + 8'h01;
			if (ovs_wrap)
				ovs_cnt <= 5'h00;
			else if (pre_wrap)
				ovs_cnt <= ovs_cnt + 5'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_out <= '0;
		end else begin
			chan_out.rts_n       <= next_rts_n;
			chan_out.rx_data_irq <= next_rx_data_irq;
			chan_out.sample_tick <= pre_wrap;
			chan_out.baud_tick   <= ovs_wrap;
		end
	end

endmodule
`default_nettype wire

/* File: tb/uls_chan_model.sv */
// Far-side channel model: queue counts and line flags
`timescale 1ns/1ps
`default_nettype none
module uls_chan_model
	import uls_pkg::*;
(
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire uls_chan_in_t want,
	output var  uls_chan_in_t chan_in
);
	// Registered so each change lands one edge after the request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_in <= '0;
		end else begin
			chan_in <= want;
		end
	end
endmodule
`default_nettype wire

/* File: tb/uls_regs_monitor.sv */
// Bus and line summary checker for the register block
`timescale 1ns/1ps
`default_nettype none
module uls_regs_monitor
	import uls_pkg::*;
(
	input wire logic                  hclk,
	input wire logic                  hresetn,
	input wire logic                  hsel,
	input wire logic [ULS_ADDR_W-1:0] haddr,
	input wire logic [1:0]            htrans,
	input wire logic                  hwrite,
	input wire logic [2:0]            hsize,
	input wire logic [ULS_BUS_W-1:0]  hwdata,
	input wire logic                  hready,
	input wire logic [ULS_BUS_W-1:0]  hrdata,
	input wire logic                  hreadyout,
	input wire logic                  hresp,
	input wire uls_chan_in_t          chan_in,
	input wire uls_chan_out_t         chan_out
);
	wire logic rd_any = hsel && hready && htrans[1] && !hwrite;
	wire logic rd_sum = rd_any && hsize == HSIZE_WORD
		&& haddr == {IDX_LINE_SUMMARY, 2'b00};
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////////////
	AST_READY: assert property (hreadyout)
		else $error("hreadyout dropped");
	AST_OKAY: assert property (!hresp)
		else $error("hresp not okay");
	AST_UPPER: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	AST_IDLE: assert property (!$past(rd_any) |-> hrdata == 32'h0)
		else $error("read data without a read");
	AST_SUM_AVAIL: assert property ($past(rd_sum) |->
		hrdata[0] == ($past(chan_in.rx_count, 2) != 8'h00))
		else $error("data available bit wrong");
	AST_SUM_ERR: assert property ($past(rd_sum) |-> hrdata[4:1] ==
		$past({chan_in.rx_break, chan_in.rx_frame_err,
		chan_in.rx_parity_err, chan_in.rx_overrun}, 2))
		else $error("receive error bits wrong");
	AST_SUM_TX: assert property ($past(rd_sum) |-> hrdata[6:5] ==
		$past({chan_in.tx_shift_empty, chan_in.tx_hold_empty}, 2))
		else $error("transmit empty bits wrong");
	AST_SUM_QERR: assert property ($past(rd_sum) |->
		hrdata[7] == $past(chan_in.rx_queue_err, 2))
		else $error("queue error bit wrong");
	////////////////////////////////////////////////////////////////////////
	cover property (rd_sum);
	cover property (chan_out.rts_n ##1 !chan_out.rts_n);
	cover property (chan_out.rx_data_irq ##1 !chan_out.rx_data_irq);
endmodule
bind uls_regs uls_regs_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .chan_in(chan_in),
	.chan_out(chan_out));
`default_nettype wire

/* File: tb/tb_uls_regs.sv */
// Self-checking bench of the level and status register block
`timescale 1ns/1ps
`default_nettype none
module tb_uls_regs;
	import uls_pkg::*;
	logic                  hclk;
	logic                  hresetn;
	logic                  hsel;
	logic [ULS_ADDR_W-1:0] haddr;
	logic [1:0]            htrans;
	logic                  hwrite;
	logic [2:0]            hsize;
	logic [ULS_BUS_W-1:0]  hwdata;
	logic [ULS_BUS_W-1:0]  hrdata;
	logic [ULS_BUS_W-1:0]  hr_s;
	logic                  hreadyout;
	logic                  hresp;
	uls_chan_in_t          want;
	uls_chan_in_t          chan_in;
	uls_chan_out_t         chan_out;
	int                    num_errors;
	int                    cmp_count;
	int                    cyc;
	int                    n;
	uls_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .chan_in(chan_in),
		.chan_out(chan_out));
	uls_chan_model far (.hclk(hclk), .hresetn(hresetn), .want(want),
		.chan_in(chan_in));
	////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// Read data is captured at the edge, before the slave clears it
	always @(posedge hclk) hr_s <= hrdata;
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end
	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task check(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {i, 2'b00};
		hsize <= HSIZE_WORD;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		#1 r = hr_s;
	endtask
	task wr(input logic [7:0] i, input logic [7:0] d);
		logic [31:0] r;
		xfer(1'b1, i, d, r);
	endtask
	task rd(input logic [7:0] i, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, i, 8'h00, r);
		check(r, e);
	endtask
	function automatic logic tick(input logic b);
		return b ? chan_out.baud_tick : chan_out.sample_tick;
	endfunction
	// Cycles between two ticks; the first wait skips a partial period
	task gap(input logic b, output int c);
		c = 0;
		while (tick(b) !== 1'b1) begin
			@(posedge hclk);
			#1;
		end
		do begin
			@(posedge hclk);
			#1;
			c++;
		end while (tick(b) !== 1'b1 && c < 1000);
	endtask
	// Inputs pass the model's register and the block's sampling stage
	task put(input logic [30:0] v);
		@(posedge hclk);
		want <= v;
		repeat (3) @(posedge hclk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
		{want, num_errors, cmp_count, cyc} = '0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 17; i <= 23; i++) rd(8'(i), 32'h0);
		for (int i = 17; i <= 19; i++) begin
			wr(8'(i), 8'(i * 5 + 3));
			rd(8'(i), 32'(i * 5 + 3));
		end
		wr(IDX_PRESCALE, 8'h2F);
		rd(IDX_PRESCALE, 32'h2F);
		wr(IDX_TX_OVS, 8'hFC);
		rd(IDX_TX_OVS, 32'h0C);
		put({8'h23, 8'h45, 8'h67, 7'h00});
		wr(IDX_SPECIAL_FN, 8'h40);
		rd(IDX_RX_STAT_CNT, 32'h23);
		wr(IDX_RX_STAT_CNT, 8'h99);
		rd(IDX_RX_STAT_CNT, 32'h23);
		wr(IDX_SPECIAL_FN, 8'h00);
		rd(IDX_RX_STAT_CNT, 32'h45);
		wr(IDX_SPECIAL_FN, 8'h80);
		rd(IDX_TX_OVS, 32'h67);
		wr(IDX_TX_OVS, 8'h03);
		wr(IDX_SPECIAL_FN, 8'h00);
		rd(IDX_TX_OVS, 32'h0C);
		rd(8'h3F, 32'h0);
		for (int i = 0; i < 8; i++) begin
			put(i == 0 ? {8'h01, 23'h0} : {24'h0, 7'(7'h40 >> (i - 1))});
			rd(IDX_LINE_SUMMARY, 32'(1 << i));
		end
		wr(IDX_RX_IRQ_THR, 8'h20);
		put({8'h1F, 23'h0});
		check(32'(chan_out.rx_data_irq), 32'h0);
		put({8'h20, 23'h0});
		check(32'(chan_out.rx_data_irq), 32'h1);
		wr(IDX_FLOW_HIGH, 8'h10);
		wr(IDX_FLOW_LOW, 8'h08);
		wr(IDX_CHAN_CTRL, 8'h03);
		put({8'h10, 23'h0});
		check(32'(chan_out.rts_n), 32'h1);
		put({8'h08, 23'h0});
		check(32'(chan_out.rts_n), 32'h1);
		put({8'h07, 23'h0});
		check(32'(chan_out.rts_n), 32'h0);
		wr(IDX_PRESCALE, 8'h02);
		gap(1'b0, n);
		check(32'(n), 32'h3);
		gap(1'b1, n);
		check(32'(n), 32'hC);
		wr(IDX_TX_OVS, 8'h0D);
		rd(IDX_TX_OVS, 32'h0D);
		gap(1'b1, n);
		check(32'(n), 32'h30);
		test_done();
	end
endmodule
`default_nettype wire
